// [sim/pdc_regs_chk.sv]
// Checker for the diagnostic register bank: APB timing and register side effects.
// Assumes it is bound to pdc_regs and sees only that module's ports.
`timescale 1ns/1ps
module pdc_regs_chk
   import pdc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PDC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Block outputs
   input wire logic [7:0] ipg_len,
   input wire logic [10:0] packet_len,
   input wire logic cable_start_pulse,
   input wire logic phy_hard_reset,
   input wire logic phy_restart,
   input wire logic standby_mode
);
   // *****************************************
   // Access decode
   // *****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Writes land at the edge where these are high
   wire logic acc = psel & penable;
   wire logic wr_acc = acc & pwrite;
   wire logic rd_acc = acc & ~pwrite;

   // *****************************************
   // Properties
   // *****************************************
   // Zero wait states, and no ready outside an access
   property p_rdy;
      pready == acc;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready not tied to access");
   // Error response only inside an access
   property p_err;
      pslverr |-> acc;
   endproperty
   a_err: assert property (p_err) else $error("pslverr outside access");
   // A start pulse needs a start write one edge before, and lasts one cycle
   property p_start;
      cable_start_pulse |-> $past(wr_acc && paddr == PDC_ADDR_CABLE && pwdata[15]) ##1 !cable_start_pulse;
   endproperty
   a_start: assert property (p_start) else $error("cable start without write");
   property p_hard;
      phy_hard_reset |-> $past(wr_acc && paddr == PDC_ADDR_RCR && pwdata[15]);
   endproperty
   a_hard: assert property (p_hard) else $error("hard reset without write");
   property p_restart;
      phy_restart |-> $past(wr_acc && paddr == PDC_ADDR_RCR && pwdata[14]);
   endproperty
   a_restart: assert property (p_restart) else $error("restart without write");
   property p_stby;
      wr_acc && paddr == PDC_ADDR_RCR && pstrb[0] |=> standby_mode == $past(pwdata[7]);
   endproperty
   a_stby: assert property (p_stby) else $error("standby not written");
   property p_ipg;
      wr_acc && paddr == PDC_ADDR_BIST1 && pstrb[0] |=> ipg_len == $past(pwdata[7:0]);
   endproperty
   a_ipg: assert property (p_ipg) else $error("gap not written");
   property p_len;
      wr_acc && paddr == PDC_ADDR_BIST2 && pstrb[1:0] == 2'h3 |=> packet_len == $past(pwdata[10:0]);
   endproperty
   a_len: assert property (p_len) else $error("length not written");
   property p_len_rsvd;
      rd_acc && paddr == PDC_ADDR_BIST2 |-> prdata[15:11] == 5'h0;
   endproperty
   a_len_rsvd: assert property (p_len_rsvd) else $error("length upper bits set");
   property p_cab_rsvd;
      rd_acc && paddr == PDC_ADDR_CABLE |-> prdata[14:2] == 13'h0;
   endproperty
   a_cab_rsvd: assert property (p_cab_rsvd) else $error("cable reserved bits set");
endmodule

bind pdc_regs pdc_regs_chk u_pdc_regs_chk (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .pready, .prdata, .pslverr, .ipg_len, .packet_len, .cable_start_pulse, .phy_hard_reset,
   .phy_restart, .standby_mode);

// [sim/pdc_regs_tb_top.sv]
// Self-checking bench for the diagnostic register bank, driven over APB.
// Assumes pdc_pkg and pdc_regs; the bench drives events, errors and cable results itself.
`timescale 1ns/1ps
module pdc_regs_tb_top;
   import pdc_pkg::*;
   // *****************************************
   // Stimulus and observed signals
   // *****************************************
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [2:0] evt = 3'h0; // {por, noframe, sleep}
   logic err = 1'b0;
   logic wrap = 1'b0;
   logic [1:0] cab = 2'h0; // {done, fail}
   logic pready, pslverr, slv, event_irq, cable_start_pulse, phy_hard_reset, phy_restart, standby_mode;
   logic [31:0] prdata, rdata;
   logic [7:0] ipg_len;
   logic [10:0] packet_len;
   int miscompares = 0;
   int tests_run = 0;
   int n_start = 0;
   int n_hard = 0;
   int n_rst = 0;

   always #50 core_clk = ~core_clk;

   pdc_regs u_pdc_regs (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .por_done_evt(evt[2]), .no_frame_evt(evt[1]), .low_power_sleep_evt(evt[0]),
      .prbs_byte_err(err), .err_cnt_wrap_mode(wrap), .ipg_len, .packet_len, .cable_start_pulse,
      .cable_done_evt(cab[1]), .cable_fail_evt(cab[0]), .phy_hard_reset, .phy_restart, .standby_mode,
      .event_irq);

   // Pulse counters; pulses last one cycle, so a count catches doubles too
   always @(posedge core_clk) begin
      if (cable_start_pulse === 1'b1) n_start <= n_start + 1;
      if (phy_hard_reset === 1'b1) n_hard <= n_hard + 1;
      if (phy_restart === 1'b1) n_rst <= n_rst + 1;
   end

   // *****************************************
   // Tasks
   // *****************************************
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer; the 1 ns delay after it lets the edge's register updates settle before the caller checks outputs
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      rdata = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         miscompares++;
         summarize();
      end
      #1;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rdata, e);
   endtask

   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk) evt <= v;
      @(posedge core_clk) evt <= 3'h0;
      @(posedge core_clk);
   endtask

   // Error strobe held for k edges counts k bytes
   task automatic errs(input int k);
      @(posedge core_clk) err <= 1'b1;
      repeat (k) @(posedge core_clk);
      err <= 1'b0;
   endtask

   task automatic cabev(input logic [1:0] v);
      @(posedge core_clk) cab <= v;
      @(posedge core_clk) cab <= 2'h0;
   endtask

   // *****************************************
   // Main sequence
   // *****************************************
   initial begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      rd(PDC_ADDR_EVT, 32'h10);
      rd(PDC_ADDR_BIST1, 32'h7d);
      rd(PDC_ADDR_BIST2, 32'h5ee);
      rd(PDC_ADDR_CABLE, 32'h0);
      rd(PDC_ADDR_RCR, 32'h0);
      rd(10'h004, 32'h0);
      chk("slverr", {31'h0, slv}, 32'h1);
      $display("test reset done");
      pulse(3'h4);
      chk("irq", {31'h0, event_irq}, 32'h1);
      rd(PDC_ADDR_EVT, 32'h1010);
      rd(PDC_ADDR_EVT, 32'h10);
      chk("irq", {31'h0, event_irq}, 32'h0);
      pulse(3'h3);
      chk("irq", {31'h0, event_irq}, 32'h0);
      wr(PDC_ADDR_EVT, 32'hf);
      chk("irq", {31'h0, event_irq}, 32'h1);
      rd(PDC_ADDR_EVT, 32'h90f);
      rd(PDC_ADDR_EVT, 32'hf);
      @(posedge core_clk) evt <= 3'h1;
      rd(PDC_ADDR_EVT, 32'h10f);
      @(posedge core_clk) evt <= 3'h0;
      rd(PDC_ADDR_EVT, 32'h10f);
      rd(PDC_ADDR_EVT, 32'hf);
      $display("test events done");
      errs(5);
      rd(PDC_ADDR_BIST1, 32'h7d);
      wr(PDC_ADDR_BIST1, 32'h8033);
      chk("ipg", {24'h0, ipg_len}, 32'h33);
      rd(PDC_ADDR_BIST1, 32'h533);
      errs(3);
      rd(PDC_ADDR_BIST1, 32'h533);
      wr(PDC_ADDR_BIST1, 32'h8033);
      rd(PDC_ADDR_BIST1, 32'h333);
      errs(300);
      wr(PDC_ADDR_BIST1, 32'h8033);
      rd(PDC_ADDR_BIST1, 32'hff33);
      @(posedge core_clk) wrap <= 1'b1;
      errs(300);
      wr(PDC_ADDR_BIST1, 32'h8033);
      rd(PDC_ADDR_BIST1, 32'h2c33);
      wr(PDC_ADDR_BIST2, 32'hffffffff);
      chk("len", {21'h0, packet_len}, 32'h7ff);
      rd(PDC_ADDR_BIST2, 32'h7ff);
      // Low byte lane only: upper bits kept and no lock without lane one
      @(posedge core_clk) pstrb <= 4'h1;
      wr(PDC_ADDR_BIST2, 32'h0);
      wr(PDC_ADDR_BIST1, 32'h8044);
      @(posedge core_clk) pstrb <= 4'hf;
      rd(PDC_ADDR_BIST2, 32'h700);
      rd(PDC_ADDR_BIST1, 32'h2c44);
      $display("test selftest done");
      wr(PDC_ADDR_CABLE, 32'h8000);
      rd(PDC_ADDR_CABLE, 32'h8000);
      cabev(2'h2);
      rd(PDC_ADDR_CABLE, 32'h2);
      wr(PDC_ADDR_CABLE, 32'hffff);
      cabev(2'h1);
      rd(PDC_ADDR_CABLE, 32'h3);
      chk("starts", n_start, 32'h2);
      $display("test cable done");
      wr(PDC_ADDR_RCR, 32'h80);
      chk("stby", {31'h0, standby_mode}, 32'h1);
      wr(PDC_ADDR_RCR, 32'h4080);
      rd(PDC_ADDR_RCR, 32'h80);
      chk("restart", n_rst, 32'h1);
      wr(PDC_ADDR_RCR, 32'h8080);
      repeat (2) @(posedge core_clk);
      rd(PDC_ADDR_BIST2, 32'h5ee);
      rd(PDC_ADDR_EVT, 32'h10);
      rd(PDC_ADDR_BIST1, 32'h7d);
      chk("hard", n_hard, 32'h1);
      chk("stby", {31'h0, standby_mode}, 32'h0);
      $display("test reset control done");
      summarize();
   end
endmodule

// [src/pdc_err_counter.sv]
// Self-test errored-byte counter with lock-and-clear capture.
// Assumes error strobes and lock requests come from logic on core_clk.
`timescale 1ns/1ps
module pdc_err_counter
   import pdc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Control
   input wire logic clear,
   input wire logic wrap_mode,
   input wire logic byte_err,
   input wire logic lock,
   // Result
   output logic [7:0] locked_count
);

   pdc_cnt_state_t s;
   pdc_cnt_state_t next_s;

   // Saturate at full scale unless wrapping is selected
   function automatic logic [7:0] bump(input logic [7:0] v, input logic wrap);
      logic [7:0] r;
      r = v;
      if (wrap || v != PDC_ERR_MAX) begin
         r = 8'(v + 8'h01);
      end
      return r;
   endfunction

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_s = s;
      if (clear) begin
         next_s = '0;
      end else if (lock) begin
         // An error in the lock cycle goes to the snapshot, so none is lost
         next_s.locked = byte_err ? bump(s.running, wrap_mode) : s.running;
         next_s.running = 8'h00;
      end else if (byte_err) begin
         next_s.running = bump(s.running, wrap_mode);
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign locked_count = s.locked;

endmodule

// [src/pdc_pkg.sv]
// Constants and types for the diagnostic control register bank of a single-pair Ethernet PHY.
// Assumes an APB master on the core clock; byte address is four times the register index.
package pdc_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int PDC_ADDR_W = 10;
   localparam logic [7:0] PDC_IDX_EVT = 8'h18;
   localparam logic [7:0] PDC_IDX_BIST1 = 8'h1b;
   localparam logic [7:0] PDC_IDX_BIST2 = 8'h1c;
   localparam logic [7:0] PDC_IDX_CABLE = 8'h1e;
   localparam logic [7:0] PDC_IDX_RCR = 8'h1f;
   localparam logic [9:0] PDC_ADDR_EVT = {PDC_IDX_EVT, 2'b00};
   localparam logic [9:0] PDC_ADDR_BIST1 = {PDC_IDX_BIST1, 2'b00};
   localparam logic [9:0] PDC_ADDR_BIST2 = {PDC_IDX_BIST2, 2'b00};
   localparam logic [9:0] PDC_ADDR_CABLE = {PDC_IDX_CABLE, 2'b00};
   localparam logic [9:0] PDC_ADDR_RCR = {PDC_IDX_RCR, 2'b00};

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int PDC_STS_POR = 12;
   localparam int PDC_STS_NOFRAME = 11;
   localparam int PDC_STS_SLEEP = 8;
   localparam int PDC_ENA_POR = 4;
   localparam int PDC_ENA_NOFRAME = 3;
   localparam int PDC_ENA_SLEEP = 0;
   localparam int PDC_ENA_RSVD_LO = 1;
   localparam int PDC_ERR_LSB = 8;
   localparam int PDC_LOCK_BIT = 15;
   localparam int PDC_CABLE_START = 15;
   localparam int PDC_CABLE_DONE = 1;
   localparam int PDC_CABLE_FAIL = 0;
   localparam int PDC_RCR_HARD = 15;
   localparam int PDC_RCR_RESTART = 14;
   localparam int PDC_RCR_STANDBY = 7;
   localparam int PDC_RCR_HI_LSB = 8;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [2:0] PDC_ENA_RST = 3'h4;
   localparam logic [7:0] PDC_IPG_RST = 8'h7d;
   localparam logic [10:0] PDC_PKT_LEN_RST = 11'h5ee;
   localparam logic [7:0] PDC_ERR_MAX = 8'hff;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      PDC_CABLE_IDLE = 2'h0,
      PDC_CABLE_RUN = 2'h1
   } pdc_cable_st_t;

   typedef struct packed {
      logic [7:0] running;
      logic [7:0] locked;
   } pdc_cnt_state_t;

   typedef struct packed {
      logic [2:0] sts;          // {por, noframe, sleep}
      logic [2:0] ena;          // {por, noframe, sleep}
      logic [1:0] ena_rsvd;
      logic [7:0] ipg;
      logic [10:0] pkt_len;
      pdc_cable_st_t cable;
      logic cable_done;
      logic cable_fail;
      logic cable_start;
      logic [5:0] rcr_hi;
      logic standby;
      logic [6:0] rcr_lo;
      logic hard_reset;
      logic restart;
      logic [31:0] rdata;
      logic slverr;
      logic [2:0] rd_sts;       // Status bits handed out in the pending read
   } pdc_state_t;

endpackage

// [src/pdc_regs.sv]
// Diagnostic control register bank: event status, self-test, cable reflectometry, reset control.
// Assumes an APB master and event sources on core_clk; nrst is synchronous, active low.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module pdc_regs
   import pdc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PDC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Event sources, one-cycle or level
   input wire logic por_done_evt,
   input wire logic no_frame_evt,
   input wire logic low_power_sleep_evt,
   // Self-test checker
   input wire logic prbs_byte_err,
   input wire logic err_cnt_wrap_mode,
   output logic [7:0] ipg_len,
   output logic [10:0] packet_len,
   // Cable reflectometry engine
   output logic cable_start_pulse,
   input wire logic cable_done_evt,
   input wire logic cable_fail_evt,
   // Transceiver control
   output logic phy_hard_reset,
   output logic phy_restart,
   output logic standby_mode,
   // Interrupt
   output logic event_irq
);

   pdc_state_t s;
   pdc_state_t next_s;
   pdc_state_t rst_s;

   logic [4:0] sel;
   logic [4:0] wr_sel;
   logic setup;
   logic wr_done;
   logic rd_done;
   logic [2:0] evt;
   logic [7:0] err_locked;
   logic err_lock;
   logic [15:0] wval_bist1;

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // One-hot register select: evt, bist1, bist2, cable, rcr
   function automatic logic [4:0] reg_sel(input logic [PDC_ADDR_W-1:0] a);
      logic [4:0] r;
      r = 5'h00;
      case (a)
         PDC_ADDR_EVT: r = 5'h01;
         PDC_ADDR_BIST1: r = 5'h02;
         PDC_ADDR_BIST2: r = 5'h04;
         PDC_ADDR_CABLE: r = 5'h08;
         PDC_ADDR_RCR: r = 5'h10;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   // Merge write data into the old value under the two low byte strobes
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // ***************************************************************
   // Bus phases
   // ***************************************************************

   // Zero wait states: every access completes in its first access cycle
   assign sel = reg_sel(paddr);
   assign setup = psel && !penable;
   assign wr_done = psel && penable && pwrite && !s.slverr;
   assign rd_done = psel && penable && !pwrite;
   assign wr_sel = wr_done ? sel : 5'h00;
   assign pready = psel && penable;
   assign prdata = s.rdata;
   assign pslverr = psel && penable && s.slverr;

   // Events in status-bit order {por, noframe, sleep}
   assign evt = {por_done_evt, no_frame_evt, low_power_sleep_evt};

   // ***************************************************************
   // Self-test error counter
   // ***************************************************************

   // Lock only when the high byte lane is written with bit 15 set
   assign wval_bist1 = merge(16'h0000, pwdata, pstrb);
   assign err_lock = wr_sel[1] && pstrb[1] && wval_bist1[PDC_LOCK_BIT];

   pdc_err_counter u_err_counter (
      .core_clk(core_clk),
      .nrst(nrst),
      .clear(s.hard_reset),
      .wrap_mode(err_cnt_wrap_mode),
      .byte_err(prbs_byte_err),
      .lock(err_lock),
      .locked_count(err_locked)
   );

   // ***************************************************************
   // Reset image
   // ***************************************************************

   // The hard-reset bit loads this image; register reset sets the same values directly
   always_comb begin
      rst_s = '0;
      rst_s.ena = PDC_ENA_RST;
      rst_s.ipg = PDC_IPG_RST;
      rst_s.pkt_len = PDC_PKT_LEN_RST;
      rst_s.cable = PDC_CABLE_IDLE;
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic [15:0] v;
      logic [2:0] clr;
      v = 16'h0000;
      clr = 3'h0;
      next_s = s;

      // Pulses last one cycle
      next_s.cable_start = 1'b0;
      next_s.hard_reset = 1'b0;
      next_s.restart = 1'b0;

      // Read clear takes only bits handed out; a fresh event still sets
      if (rd_done && sel[0]) begin
         clr = s.rd_sts;
      end
      next_s.sts = (s.sts & ~clr) | evt;

      // Event enables and reserved read-write bits
      if (wr_sel[0]) begin
         v = merge({11'h000, s.ena[2:1], s.ena_rsvd, s.ena[0]}, pwdata, pstrb);
         next_s.ena = {v[PDC_ENA_POR], v[PDC_ENA_NOFRAME], v[PDC_ENA_SLEEP]};
         next_s.ena_rsvd = v[PDC_ENA_RSVD_LO +: 2];
      end

      // Gap length; the error byte itself is read-only
      if (wr_sel[1]) begin
         v = merge({8'h00, s.ipg}, pwdata, pstrb);
         next_s.ipg = v[7:0];
      end

      // Packet length; bits above 10 are dropped
      if (wr_sel[2]) begin
         v = merge({5'h00, s.pkt_len}, pwdata, pstrb);
         next_s.pkt_len = v[10:0];
      end

      // Cable measurement sequence
      case (s.cable)
         PDC_CABLE_IDLE: begin
            if (wr_sel[3]) begin
               v = merge(16'h0000, pwdata, pstrb);
               if (v[PDC_CABLE_START]) begin
                  next_s.cable = PDC_CABLE_RUN;
                  next_s.cable_start = 1'b1;
                  next_s.cable_done = 1'b0;
                  next_s.cable_fail = 1'b0;
               end
            end
         end
         PDC_CABLE_RUN: begin
            // Start bit reads one until the engine reports, then clears itself
            if (cable_done_evt || cable_fail_evt) begin
               next_s.cable = PDC_CABLE_IDLE;
               next_s.cable_done = 1'b1;
               next_s.cable_fail = cable_fail_evt;
            end
         end
         default: begin
            next_s.cable = PDC_CABLE_IDLE;
         end
      endcase

      // Reset and standby control
      if (wr_sel[4]) begin
         v = merge({2'b00, s.rcr_hi, s.standby, s.rcr_lo}, pwdata, pstrb);
         next_s.hard_reset = v[PDC_RCR_HARD];
         next_s.restart = v[PDC_RCR_RESTART];
         next_s.rcr_hi = v[PDC_RCR_HI_LSB +: 6];
         next_s.standby = v[PDC_RCR_STANDBY];
         next_s.rcr_lo = v[6:0];
      end

      // Read data and error are captured in the setup cycle
      if (setup) begin
         next_s.slverr = (sel == 5'h00);
         next_s.rd_sts = 3'h0;
         next_s.rdata = 32'h0000_0000;
         case (sel)
            5'h01: begin
               next_s.rd_sts = s.sts;
               next_s.rdata[PDC_STS_POR] = s.sts[2];
               next_s.rdata[PDC_STS_NOFRAME] = s.sts[1];
               next_s.rdata[PDC_STS_SLEEP] = s.sts[0];
               next_s.rdata[PDC_ENA_POR] = s.ena[2];
               next_s.rdata[PDC_ENA_NOFRAME] = s.ena[1];
               next_s.rdata[PDC_ENA_RSVD_LO +: 2] = s.ena_rsvd;
               next_s.rdata[PDC_ENA_SLEEP] = s.ena[0];
            end
            5'h02: begin
               next_s.rdata[15:0] = {err_locked, s.ipg};
            end
            5'h04: begin
               next_s.rdata[10:0] = s.pkt_len;
            end
            5'h08: begin
               // Bits 14:2 stay zero
               next_s.rdata[PDC_CABLE_START] = (s.cable == PDC_CABLE_RUN);
               next_s.rdata[PDC_CABLE_DONE] = s.cable_done;
               next_s.rdata[PDC_CABLE_FAIL] = s.cable_fail;
            end
            5'h10: begin
               // Self-clearing bits always read zero
               next_s.rdata[15:0] = {2'b00, s.rcr_hi, s.standby, s.rcr_lo};
            end
            default: begin
               next_s.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Hard reset returns every register to its reset value, as the pin does
      if (s.hard_reset) begin
         next_s = rst_s;
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s <= '0;
         s.ena <= PDC_ENA_RST;
         s.ipg <= PDC_IPG_RST;
         s.pkt_len <= PDC_PKT_LEN_RST;
         s.cable <= PDC_CABLE_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign ipg_len = s.ipg;
   assign packet_len = s.pkt_len;
   assign cable_start_pulse = s.cable_start;
   assign phy_hard_reset = s.hard_reset;
   assign phy_restart = s.restart;
   assign standby_mode = s.standby;
   assign event_irq = |(s.sts & s.ena);

endmodule
